// File: verilog/rmcg_defs.vh
// register map, field layout and reset values of the run-mode clock gating block
`ifndef RMCG_DEFS_VH
`define RMCG_DEFS_VH

// register byte offsets within the system control window
`define RMCG_OFF_RUN_CLOCK_CONFIG   12'h060
`define RMCG_OFF_RUN_GATE_FIRST     12'h104
`define RMCG_OFF_RUN_GATE_SECOND    12'h108
`define RMCG_OFF_SLEEP_GATE_SECOND  12'h118
`define RMCG_OFF_DEEP_GATE_SECOND   12'h128
`define RMCG_OFF_IRQ_STATUS         12'h1F0
`define RMCG_OFF_IRQ_MASK           12'h1F4

// reset values
`define RMCG_RST_GATE               32'h00000000
`define RMCG_RST_CLOCK_CONFIG       32'h00000000
`define RMCG_RST_IRQ                32'h00000000

// writable bit masks, everything else reads zero
`define RMCG_MASK_FIRST             32'h00000007
`define RMCG_MASK_SECOND            32'h0001201F
`define RMCG_MASK_CLOCK_CONFIG      32'h08000000
`define RMCG_MASK_IRQ               32'h00000003

// field positions
`define RMCG_BIT_SERIAL_PORT0       0
`define RMCG_BIT_SERIAL_PORT1       1
`define RMCG_BIT_SERIAL_PORT2       2
`define RMCG_BIT_PORT_A             0
`define RMCG_BIT_PORT_E             4
`define RMCG_BIT_MICRO_DMA          13
`define RMCG_BIT_USB_PORT           16
`define RMCG_BIT_AUTO_GATE_SELECT   27
`define RMCG_BIT_IRQ_GATED_ACCESS   0
`define RMCG_BIT_IRQ_BAD_ADDRESS    1

// gated module count and index layout
`define RMCG_NUM_MODULES            10
`define RMCG_IDX_USB_PORT           3
`define RMCG_IDX_MICRO_DMA          4
`define RMCG_IDX_PORT_A             5

// power modes
`define RMCG_MODE_RUN               2'b00
`define RMCG_MODE_SLEEP             2'b01
`define RMCG_MODE_DEEP              2'b10

`endif

// File: verilog/rmcg_top.v
// run-mode peripheral clock gating with sleep copies, apb registers and access faults
`timescale 1ns/1ps
`include "rmcg_defs.vh"

// Functional notes
// - bits 2, 1, 0 enable clocks of serial ports 2, 1, 0
// - any access to an unclocked module gets a bus fault answer
// - all gating enables reset to zero, every module starts unclocked
// - second run gating register at 0x108, read/write, resets to zero
// - bit 16 of second run gating register clocks the usb module
// - bit 13 of second run gating register clocks the micro-dma controller
// - bits 4 down to 0 clock gpio ports E, D, C, B, A
// - reserved bits read zero; software preserves them on updates
// - run register rules normal running; sleep, deep-sleep copies rule low power
// - sleep copies used only when auto-gate select is set
// - sleep gating register at 0x118 with same layout as run register
module rmcg_top
#(
  parameter NMOD = `RMCG_NUM_MODULES
)
(
  input  wire             clk_sys,
  input  wire             rst_n,
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [11:0]      paddr,
  input  wire [31:0]      pwdata,
  input  wire [3:0]       pstrb,
  output reg  [31:0]      prdata,
  output reg              pready,
  output reg              pslverr,
  input  wire             sleep_req,
  input  wire             deepsleep_req,
  input  wire [NMOD-1:0]  mod_access,
  output reg  [NMOD-1:0]  mod_clk_en_q,
  output wire [NMOD-1:0]  mod_gclk,
  output reg  [NMOD-1:0]  mod_fault_q,
  output reg  [NMOD-1:0]  mod_ack_q,
  output reg  [1:0]       power_mode_q,
  output reg              irq_q
);

  // reset copy, registers and decode helpers
  reg  [1:0]       rst_sync_q;
  wire             rst_int_n;
  reg  [31:0]      run_first_q;
  reg  [31:0]      run_second_q;
  reg  [31:0]      sleep_second_q;
  reg  [31:0]      deep_second_q;
  reg  [31:0]      clock_config_q;
  reg  [31:0]      irq_status_q;
  reg  [31:0]      irq_mask_q;
  reg  [NMOD-1:0]  mod_en_d;
  reg  [NMOD-1:0]  mod_en_neg_q;
  reg  [1:0]       power_mode_d;
  reg  [31:0]      rdata_d;
  reg              hit_d;
  wire             setup_ph;
  wire             write_go;
  wire             auto_gate_select;
  wire             gated_access;
  wire             bad_addr_ev;
  wire [31:0]      irq_set;
  wire [31:0]      irq_clr;

  // merge write data into a register under byte strobes and writable mask
  function [31:0] rmcg_merge;
    input [31:0] old_val;
    input [31:0] wdata;
    input [3:0]  strb;
    input [31:0] wmask;
    integer      i;
    reg   [31:0] res;
    begin
      res = old_val;
      for (i = 0; i < 32; i = i + 1)
      begin
        if (strb[i / 8] && wmask[i])
        begin
          res[i] = wdata[i];
        end
      end
      rmcg_merge = res & wmask;
    end
  endfunction

  // expand first and second gating words into the module enable vector
  function [`RMCG_NUM_MODULES-1:0] rmcg_mods;
    input [31:0] first_w;
    input [31:0] second_w;
    begin
      rmcg_mods = {second_w[`RMCG_BIT_PORT_E:`RMCG_BIT_PORT_A],
                   second_w[`RMCG_BIT_MICRO_DMA],
                   second_w[`RMCG_BIT_USB_PORT],
                   first_w[`RMCG_BIT_SERIAL_PORT2],
                   first_w[`RMCG_BIT_SERIAL_PORT1],
                   first_w[`RMCG_BIT_SERIAL_PORT0]};
    end
  endfunction

  // reset release through two flip-flops
  // assert at once, release only after two clean edges so no flop sees a ragged release
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_sync_q <= 2'b00;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // internal reset copy used by every synchronous clear below
  assign rst_int_n = rst_sync_q[1];

  // apb phases: data and answer prepared in setup, taken in access
  // pready low in setup keeps a held request from being answered a second time
  assign setup_ph = psel && !penable && !pready;
  assign write_go = psel && penable && pready && pwrite && !pslverr;
  assign auto_gate_select = clock_config_q[`RMCG_BIT_AUTO_GATE_SELECT];

  // read mux and address decode
  // unmapped offsets read as zero and raise a slave error
  always @*
  begin
    rdata_d = 32'h00000000;
    hit_d   = 1'b1;
    case (paddr)
      `RMCG_OFF_RUN_CLOCK_CONFIG:  rdata_d = clock_config_q;
      `RMCG_OFF_RUN_GATE_FIRST:    rdata_d = run_first_q;
      `RMCG_OFF_RUN_GATE_SECOND:   rdata_d = run_second_q;
      `RMCG_OFF_SLEEP_GATE_SECOND: rdata_d = sleep_second_q;
      `RMCG_OFF_DEEP_GATE_SECOND:  rdata_d = deep_second_q;
      `RMCG_OFF_IRQ_STATUS:        rdata_d = irq_status_q;
      `RMCG_OFF_IRQ_MASK:          rdata_d = irq_mask_q;
      default:                     hit_d   = 1'b0;
    endcase
  end

  // apb answer flops, one cycle after setup
  // write answers carry zero data so no stale register value is driven
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (!rst_int_n)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata  <= pwrite ? 32'h00000000 : rdata_d;  // reserved bits already zero
      pready  <= 1'b1;
      pslverr <= !hit_d;
    end
    else
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // gating and configuration registers
  // reserved and strobed-off bits keep their value; reserved bits stay zero
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_first_q    <= `RMCG_RST_GATE;
      run_second_q   <= `RMCG_RST_GATE;
      sleep_second_q <= `RMCG_RST_GATE;
      deep_second_q  <= `RMCG_RST_GATE;
      clock_config_q <= `RMCG_RST_CLOCK_CONFIG;
      irq_mask_q     <= `RMCG_RST_IRQ;
    end
    else if (!rst_int_n)
    begin
      run_first_q    <= `RMCG_RST_GATE;
      run_second_q   <= `RMCG_RST_GATE;
      sleep_second_q <= `RMCG_RST_GATE;
      deep_second_q  <= `RMCG_RST_GATE;
      clock_config_q <= `RMCG_RST_CLOCK_CONFIG;
      irq_mask_q     <= `RMCG_RST_IRQ;
    end
    else if (write_go)
    begin
      case (paddr)
        `RMCG_OFF_RUN_CLOCK_CONFIG:
          clock_config_q <= rmcg_merge(clock_config_q, pwdata, pstrb,
                                       `RMCG_MASK_CLOCK_CONFIG);
        `RMCG_OFF_RUN_GATE_FIRST:
          run_first_q <= rmcg_merge(run_first_q, pwdata, pstrb, `RMCG_MASK_FIRST);
        `RMCG_OFF_RUN_GATE_SECOND:
          run_second_q <= rmcg_merge(run_second_q, pwdata, pstrb, `RMCG_MASK_SECOND);
        `RMCG_OFF_SLEEP_GATE_SECOND:
          sleep_second_q <= rmcg_merge(sleep_second_q, pwdata, pstrb, `RMCG_MASK_SECOND);
        `RMCG_OFF_DEEP_GATE_SECOND:
          deep_second_q <= rmcg_merge(deep_second_q, pwdata, pstrb, `RMCG_MASK_SECOND);
        `RMCG_OFF_IRQ_MASK:
          irq_mask_q <= rmcg_merge(irq_mask_q, pwdata, pstrb, `RMCG_MASK_IRQ);
        default:
          irq_mask_q <= irq_mask_q;
      endcase
    end
  end

  // power mode from core requests, deep sleep takes priority
  // requests come from logic on this clock, so no synchroniser is needed
  always @*
  begin
    if (deepsleep_req)
    begin
      power_mode_d = `RMCG_MODE_DEEP;
    end
    else if (sleep_req)
    begin
      power_mode_d = `RMCG_MODE_SLEEP;
    end
    else
    begin
      power_mode_d = `RMCG_MODE_RUN;
    end
  end

  // effective enables: low-power copies only under auto-gate select
  // serial port enables have no low-power copies and follow the run value
  always @*
  begin
    case (power_mode_q)
      `RMCG_MODE_RUN:
        mod_en_d = rmcg_mods(run_first_q, run_second_q);
      `RMCG_MODE_SLEEP:
        mod_en_d = auto_gate_select ? rmcg_mods(run_first_q, sleep_second_q)
                                    : rmcg_mods(run_first_q, run_second_q);
      `RMCG_MODE_DEEP:
        mod_en_d = auto_gate_select ? rmcg_mods(run_first_q, deep_second_q)
                                    : rmcg_mods(run_first_q, run_second_q);
      default:
        mod_en_d = rmcg_mods(run_first_q, run_second_q);
    endcase
  end

  // mode and enable flops
  // enables lag the register write by one cycle; access checks use this copy
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      power_mode_q <= `RMCG_MODE_RUN;
      mod_clk_en_q <= {NMOD{1'b0}};
    end
    else if (!rst_int_n)
    begin
      power_mode_q <= `RMCG_MODE_RUN;
      mod_clk_en_q <= {NMOD{1'b0}};
    end
    else
    begin
      power_mode_q <= power_mode_d;
      mod_clk_en_q <= mod_en_d;
    end
  end

  // enable copy taken on the falling edge, steady through the high phase
  // changing only while the clock is low, the and gate cannot chop a pulse
  always @(negedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mod_en_neg_q <= {NMOD{1'b0}};
    end
    else
    begin
      mod_en_neg_q <= mod_clk_en_q;
    end
  end

  // gated module clocks, no runt pulse possible
  // a plain and gate here; a real netlist would use a clock gating cell
  assign mod_gclk = {NMOD{clk_sys}} & mod_en_neg_q;

  // module access check: fault for unclocked, ack for clocked
  // exactly one of fault or ack answers each access pulse
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mod_fault_q <= {NMOD{1'b0}};
      mod_ack_q   <= {NMOD{1'b0}};
    end
    else if (!rst_int_n)
    begin
      mod_fault_q <= {NMOD{1'b0}};
      mod_ack_q   <= {NMOD{1'b0}};
    end
    else
    begin
      mod_fault_q <= mod_access & ~mod_clk_en_q;
      mod_ack_q   <= mod_access & mod_clk_en_q;
    end
  end

  // interrupt events and write-one-to-clear, set wins over clear
  // bit 0 flags gated-module accesses, bit 1 unmapped bus accesses
  assign gated_access = |(mod_access & ~mod_clk_en_q);
  assign bad_addr_ev  = psel && penable && pready && pslverr;
  assign irq_set      = {30'h00000000, bad_addr_ev, gated_access};
  assign irq_clr      = (write_go && paddr == `RMCG_OFF_IRQ_STATUS)
                        ? rmcg_merge(32'h00000000, pwdata, pstrb, `RMCG_MASK_IRQ)
                        : 32'h00000000;

  // sticky status and level interrupt, the line follows masked status by one cycle
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_status_q <= `RMCG_RST_IRQ;
      irq_q        <= 1'b0;
    end
    else if (!rst_int_n)
    begin
      irq_status_q <= `RMCG_RST_IRQ;
      irq_q        <= 1'b0;
    end
    else
    begin
      irq_status_q <= ((irq_status_q & ~irq_clr) | irq_set) & `RMCG_MASK_IRQ;
      irq_q        <= |(irq_status_q & irq_mask_q);
    end
  end

endmodule // rmcg_top

// File: test/rmcg_checker.sv
// port assertions of the gating block
`timescale 1ns/1ps
`include "rmcg_defs.vh"
module rmcg_checker
#(
  parameter NMOD = 10
)
(
  input wire            clk_sys,
  input wire            rst_n,
  input wire            psel,
  input wire            penable,
  input wire            pready,
  input wire            pslverr,
  input wire            sleep_req,
  input wire            deepsleep_req,
  input wire [NMOD-1:0] mod_access,
  input wire [NMOD-1:0] mod_clk_en_q,
  input wire [NMOD-1:0] mod_gclk,
  input wire [NMOD-1:0] mod_fault_q,
  input wire [NMOD-1:0] mod_ack_q,
  input wire [1:0]      power_mode_q
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  a_setup_answer: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_fault_gated: assert property ((|mod_access) |=>
    mod_fault_q == $past(mod_access & ~mod_clk_en_q)) else $error("fault wrong");
  a_ack_clocked: assert property ((|mod_access) |=>
    mod_ack_q == $past(mod_access & mod_clk_en_q)) else $error("ack wrong");
  a_deep_wins: assert property (deepsleep_req |=> power_mode_q == `RMCG_MODE_DEEP)
    else $error("deep mode missed");
  a_run_mode: assert property (!sleep_req && !deepsleep_req |=> power_mode_q == 2'b00)
    else $error("run mode missed");
  a_gclk_clean: assert property (@(negedge clk_sys) 1 |=>
    mod_gclk == $past(mod_clk_en_q)) else $error("gated clock wrong");
  // main scenarios reached
  c_fault: cover property (|mod_fault_q);
  c_ack: cover property (|mod_ack_q);
  c_sleep: cover property (power_mode_q == `RMCG_MODE_SLEEP);
endmodule // rmcg_checker

bind rmcg_top rmcg_checker #(.NMOD(NMOD)) u_rmcg_checker (.clk_sys(clk_sys), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req),
  .deepsleep_req(deepsleep_req), .mod_access(mod_access), .mod_clk_en_q(mod_clk_en_q),
  .mod_gclk(mod_gclk), .mod_fault_q(mod_fault_q), .mod_ack_q(mod_ack_q),
  .power_mode_q(power_mode_q));

// File: test/rmcg_mods.sv
// model of the gated modules: accesses and clock tick counts
`timescale 1ns/1ps
module rmcg_mods
(
  input  wire       clk_sys,
  input  wire [9:0] mod_gclk,
  input  wire [9:0] mod_ack_q,
  input  wire [9:0] mod_fault_q,
  output reg  [9:0] mod_access
);
  integer ticks [0:9];
  genvar  g;
  initial mod_access = 10'h000;
  // count rising edges of each gated clock
  generate
    for (g = 0; g < 10; g = g + 1)
    begin : g_tick
      initial ticks[g] = 0;
      always @(posedge mod_gclk[g]) ticks[g] = ticks[g] + 1;
    end
  endgenerate
  // one access pulse, answer taken one cycle later
  task access(input integer i, output [1:0] res);
    begin
      mod_access <= 10'h001 << i;
      @(posedge clk_sys);
      mod_access <= 10'h000;
      @(posedge clk_sys);
      res = {mod_ack_q[i], mod_fault_q[i]};
    end
  endtask
endmodule // rmcg_mods

// File: test/testbench.sv
// self-checking bench of the gating block
`timescale 1ns/1ps
`include "rmcg_defs.vh"
module testbench;
  reg         clk_sys, rst_n, psel, penable, pwrite, sleep_req, deepsleep_req, e;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, r;
  reg  [3:0]  pstrb;
  reg  [1:0]  res;
  wire [31:0] prdata;
  wire        pready, pslverr, irq_q;
  wire [9:0]  acc, en, gclk, flt, ack;
  wire [1:0]  mode;
  integer     error_cnt, samples_checked, i, t0, t1;
  integer     bitpos [0:9];
  rmcg_top u_rmcg_top (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req), .deepsleep_req(deepsleep_req),
    .mod_access(acc), .mod_clk_en_q(en), .mod_gclk(gclk), .mod_fault_q(flt),
    .mod_ack_q(ack), .power_mode_q(mode), .irq_q(irq_q));
  rmcg_mods u_rmcg_mods (.clk_sys(clk_sys), .mod_gclk(gclk), .mod_ack_q(ack),
    .mod_fault_q(flt), .mod_access(acc));
  // 40 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task stop_test;
    begin
      if (error_cnt == 0 && samples_checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        error_cnt = error_cnt + 1;
      end
    end
  endtask
  // one apb transfer, then one idle cycle
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      for (n = 0; n < 16 && pready !== 1'b1; n = n + 1)
        @(posedge clk_sys);
      if (pready !== 1'b1)
      begin
        error_cnt = error_cnt + 1;
        stop_test;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    begin
      apb(1'b1, a, d);
      chk(e, 0);
    end
  endtask
  task rd(input [11:0] a, input [31:0] x, input ex);
    begin
      apb(1'b0, a, 32'h0);
      chk(r, x);
      chk(e, ex);
    end
  endtask
  // main sequence
  initial
  begin
    error_cnt = 0;
    samples_checked = 0;
    bitpos = '{0, 1, 2, 16, 13, 0, 1, 2, 3, 4};
    {rst_n, psel, penable, pwrite, sleep_req, deepsleep_req} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(`RMCG_OFF_RUN_GATE_SECOND, 32'h0, 1'b0);
    rd(`RMCG_OFF_RUN_GATE_FIRST, 32'h0, 1'b0);
    for (i = 0; i < 10; i = i + 1)
    begin
      u_rmcg_mods.access(i, res);
      chk(res, 2'b01);
    end
    // one module enabled at a time
    for (i = 0; i < 10; i = i + 1)
    begin
      wr(`RMCG_OFF_RUN_GATE_FIRST, i < 3 ? 32'h1 << bitpos[i] : 32'h0);
      wr(`RMCG_OFF_RUN_GATE_SECOND, i < 3 ? 32'h0 : 32'h1 << bitpos[i]);
      @(negedge clk_sys);
      chk(en, 10'h001 << i);
      t0 = u_rmcg_mods.ticks[i];
      t1 = u_rmcg_mods.ticks[(i + 1) % 10];
      repeat (4) @(negedge clk_sys);
      chk(u_rmcg_mods.ticks[i] - t0, 4);
      chk(u_rmcg_mods.ticks[(i + 1) % 10] - t1, 0);
      @(posedge clk_sys);
      u_rmcg_mods.access(i, res);
      chk(res, 2'b10);
    end
    // read-modify-write keeps reserved bits as they were read
    rd(`RMCG_OFF_RUN_GATE_SECOND, 32'h00000010, 1'b0);
    wr(`RMCG_OFF_RUN_GATE_SECOND, r | 32'h0001201F);
    rd(`RMCG_OFF_RUN_GATE_FIRST, 32'h00000000, 1'b0);
    wr(`RMCG_OFF_RUN_GATE_FIRST, r | 32'h00000007);
    rd(`RMCG_OFF_RUN_GATE_SECOND, 32'h0001201F, 1'b0);
    rd(`RMCG_OFF_RUN_GATE_FIRST, 32'h00000007, 1'b0);
    rd(12'h200, 32'h0, 1'b1);
    // interrupt raised, masked and cleared
    rd(`RMCG_OFF_IRQ_STATUS, 32'h3, 1'b0);
    chk(irq_q, 0);
    wr(`RMCG_OFF_IRQ_MASK, 32'h1);
    @(posedge clk_sys);
    chk(irq_q, 1);
    wr(`RMCG_OFF_IRQ_MASK, 32'h0);
    @(posedge clk_sys);
    chk(irq_q, 0);
    wr(`RMCG_OFF_IRQ_STATUS, 32'h3);
    rd(`RMCG_OFF_IRQ_STATUS, 32'h0, 1'b0);
    // sleep copies only with auto gating selected
    wr(`RMCG_OFF_SLEEP_GATE_SECOND, 32'h00002000);
    sleep_req <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(mode, 1);
    chk(en, 10'h3FF);
    wr(`RMCG_OFF_RUN_CLOCK_CONFIG, 32'h1 << `RMCG_BIT_AUTO_GATE_SELECT);
    @(posedge clk_sys);
    chk(en, 10'h017);
    deepsleep_req <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(mode, 2);
    chk(en, 10'h007);
    sleep_req <= 1'b0;
    deepsleep_req <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(en, 10'h3FF);
    // reset in mid-run
    rst_n <= 1'b0;
    @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(en, 0);
    rd(`RMCG_OFF_RUN_GATE_SECOND, 32'h0, 1'b0);
    stop_test;
  end
endmodule // testbench
